// *** src/ipv4_header_framer.v ***
// Purpose: build and check version 4 datagram headers on byte streams
// Assumes: streams synchronous to clk_i; sinks accept one byte per valid cycle
// Notes: options are summed into the checksum but otherwise skipped unchecked; a receive drop raises an error pulse
`timescale 1ns/10ps
`default_nettype none
`include "ipv4_framer_consts.vh"
module ipv4_header_framer (
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   // transmit request
   input wire tx_start_i,
   input wire [15:0] tx_total_len_i,
   input wire [7:0] tx_proto_i,
   input wire [7:0] tx_hop_limit_i,
   input wire [3:0] tx_service_type_bits_i,
   input wire [2:0] tx_flags_i,
   input wire [12:0] tx_frag_off_i,
   input wire [31:0] tx_src_addr_i,
   input wire [31:0] tx_dst_addr_i,
   // transmit header stream
   output reg tx_busy_o,
   output reg tx_valid_o,
   output reg [7:0] tx_data_o,
   output reg tx_last_o,
   output reg [15:0] tx_link_type_o,
   // receive byte stream
   input wire rx_valid_i,
   input wire [7:0] rx_data_i,
   input wire rx_first_i,
   input wire [31:0] local_addr_i,
   input wire [31:0] local_mask_i,
   // receive results
   output reg rx_hdr_ok_o,
   output reg rx_drop_o,
   output reg [2:0] rx_err_code_o,
   output reg [31:0] rx_err_src_o,
   output reg [1:0] rx_route_o,
   output reg [2:0] rx_dst_class_o,
   output reg [1:0] rx_dst_kind_o,
   output reg [15:0] rx_payload_len_o,
   output reg [15:0] rx_app_src_o,
   output reg [15:0] rx_app_dst_o,
   output reg rx_app_valid_o,
   output reg rx_pay_valid_o,
   output reg [7:0] rx_pay_data_o,
   output reg [7:0] fwd_hop_limit_o
);
   // --------------------------------------------------
   // transmit header builder
   // --------------------------------------------------
   localparam TX_IDLE = 2'h0;
   localparam TX_SUM = 2'h1;
   localparam TX_SEND = 2'h2;
   reg [1:0] tx_state;
   reg [159:0] hdr;
   reg [15:0] ident;
   reg [4:0] tx_idx;
   reg [4:0] tx_byte;
   wire [15:0] tx_sum;
   wire [3:0] svc;
   reg [3:0] svc_one;
   always @* begin
      // more than one bit set falls back to normal service
      case (tx_service_type_bits_i)
         4'h0, 4'h1, 4'h2, 4'h4, 4'h8: svc_one = tx_service_type_bits_i; // R12
         default: svc_one = 4'h0;
      endcase
   end
   assign svc = svc_one;
   wire [15:0] tx_word;
   assign tx_word = hdr[159 - {tx_idx[3:0], 4'h0} -: 16];
   ones_sum16 tx_csum (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .clear_i(tx_state == TX_IDLE),
      .add_i(tx_state == TX_SUM),
      .word_i(tx_word),
      .sum_o(tx_sum)
   );
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_state <= TX_IDLE;
         hdr <= 160'h0;
         ident <= 16'h0000;
         tx_idx <= 5'h00;
         tx_byte <= 5'h00;
         tx_busy_o <= 1'b0;
         tx_valid_o <= 1'b0;
         tx_data_o <= 8'h00;
         tx_last_o <= 1'b0;
         tx_link_type_o <= `ETH_TYPE_IPV4; // R03
      end else begin
         tx_valid_o <= 1'b0;
         tx_last_o <= 1'b0;
         case (tx_state)
            TX_IDLE: begin
               if (tx_start_i) begin
                  // checksum slot zero while summing
                  hdr <= {`IP_VERSION, `IP_MIN_IHL, 3'h0, svc, 1'b0, // R10 R08 R12 R15
                          tx_total_len_i, ident, tx_flags_i, tx_frag_off_i, // R13 R14 R15
                          tx_hop_limit_i, tx_proto_i, 16'h0000, // R01 R16 R19
                          tx_src_addr_i, tx_dst_addr_i}; // R04 R16
                  ident <= ident + 16'h0001; // R14
                  tx_idx <= 5'h00;
                  tx_busy_o <= 1'b1;
                  tx_state <= TX_SUM;
               end
            end
            TX_SUM: begin
               tx_idx <= tx_idx + 5'h01;
               if (tx_idx == 5'h09) begin
                  tx_byte <= 5'h00;
                  tx_state <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (tx_byte == 5'h00)
                  hdr[79:64] <= ~tx_sum; // R19 R17
               tx_valid_o <= (tx_byte != 5'h00);
               if (tx_byte != 5'h00)
                  tx_data_o <= hdr[159 - {tx_byte - 5'h01, 3'h0} -: 8]; // R09
               tx_byte <= tx_byte + 5'h01;
               if ({1'b0, tx_byte} == `IP_HDR_BYTES) begin
                  tx_last_o <= 1'b1;
                  tx_busy_o <= 1'b0;
                  tx_state <= TX_IDLE;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end
   // --------------------------------------------------
   // receive header checker
   // --------------------------------------------------
   // all state but tot restarts on rx_first_i, except a decision on the same edge still sets checked, and either sets pass or clears active on a drop
   reg [15:0] rx_cnt;
   reg [159:0] rhdr;
   reg [7:0] hi_byte;
   reg [3:0] ihl;
   reg [15:0] tot;
   reg active;
   reg checked;
   reg pass;
   wire [15:0] rx_sum;
   wire [5:0] hbytes;
   wire rx_take;
   wire rx_odd_word;
   wire in_hdr;
   assign hbytes = {ihl, 2'h0}; // R11
   assign rx_take = rx_valid_i && (rx_first_i || active);
   assign in_hdr = rx_first_i || (rx_cnt < {10'h000, hbytes});
   assign rx_odd_word = rx_take && !rx_first_i && rx_cnt[0] && in_hdr;
   ones_sum16 rx_csum (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .clear_i(rx_valid_i && rx_first_i),
      .add_i(rx_odd_word), // R17
      .word_i({hi_byte, rx_data_i}),
      .sum_o(rx_sum)
   );
   wire [31:0] dst;
   wire [7:0] lead;
   wire [3:0] rsvc;
   assign dst = rhdr[31:0];
   assign lead = dst[31:24];
   assign rsvc = rhdr[148:145];
   reg [2:0] next_class;
   reg [1:0] next_kind;
   reg [2:0] next_err;
   always @* begin
      if (lead <= `CLASS_A_TOP)
         next_class = `CLS_A; // R04
      else if (lead <= `CLASS_B_TOP)
         next_class = `CLS_B;
      else if (lead <= `CLASS_C_TOP)
         next_class = `CLS_C;
      else if (lead <= `CLASS_D_TOP)
         next_class = `CLS_D;
      else
         next_class = `CLS_E;
      if (next_class == `CLS_D)
         next_kind = `KIND_MULTICAST; // R05
      // host part all ones counts only on our own network; the all-ones address counts on any network
      else if (dst == 32'hFFFFFFFF || ((dst | local_mask_i) == 32'hFFFFFFFF &&
               (dst & local_mask_i) == (local_addr_i & local_mask_i)))
         next_kind = `KIND_BROADCAST;
      else
         next_kind = `KIND_UNICAST;
      // checksum over a valid header sums to all ones
      if (rhdr[159:156] != `IP_VERSION)
         next_err = `ERR_VERSION; // R10
      else if (ihl < `IP_MIN_IHL || tot < {10'h000, hbytes})
         next_err = `ERR_LENGTH; // R20 R13
      else if (rx_sum != 16'hFFFF)
         next_err = `ERR_CHECKSUM; // R19
      else if (rhdr[95:88] == 8'h00)
         next_err = `ERR_HOPS; // R18
      else if (rhdr[144] || !(rsvc == 4'h0 || rsvc == 4'h1 || rsvc == 4'h2 || rsvc == 4'h4 || rsvc == 4'h8))
         next_err = `ERR_SERVICE; // R12
      else
         next_err = 3'h0;
   end
   // short header lengths wait for the addresses too, so a drop always has a source
   wire decide;
   wire hdr_good;
   assign decide = active && !checked && rx_cnt >= {10'h000, hbytes} && rx_cnt >= {10'h000, `IP_HDR_BYTES};
   // first payload byte may arrive on the deciding edge itself
   assign hdr_good = (checked && pass) || (decide && next_err == 3'h0);
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_cnt <= 16'h0000;
         rhdr <= 160'h0;
         hi_byte <= 8'h00;
         ihl <= 4'h0;
         tot <= 16'h0000;
         active <= 1'b0;
         checked <= 1'b0;
         pass <= 1'b0;
         rx_hdr_ok_o <= 1'b0;
         rx_drop_o <= 1'b0;
         rx_err_code_o <= 3'h0;
         rx_err_src_o <= 32'h0;
         rx_route_o <= `ROUTE_OTHER;
         rx_dst_class_o <= `CLS_A;
         rx_dst_kind_o <= `KIND_UNICAST;
         rx_payload_len_o <= 16'h0000;
         rx_app_src_o <= 16'h0000;
         rx_app_dst_o <= 16'h0000;
         rx_app_valid_o <= 1'b0;
         rx_pay_valid_o <= 1'b0;
         rx_pay_data_o <= 8'h00;
         fwd_hop_limit_o <= 8'h00;
      end else begin
         rx_hdr_ok_o <= 1'b0;
         rx_drop_o <= 1'b0;
         rx_app_valid_o <= 1'b0;
         rx_pay_valid_o <= 1'b0;
         if (rx_take) begin
            hi_byte <= rx_data_i;
            if (rx_first_i) begin
               rx_cnt <= 16'h0001; // R07
               rhdr <= {rx_data_i, 152'h0};
               ihl <= rx_data_i[3:0];
               active <= 1'b1;
               checked <= 1'b0;
               pass <= 1'b0;
            end else begin
               rx_cnt <= rx_cnt + 16'h0001;
               if (rx_cnt < {10'h000, `IP_HDR_BYTES})
                  rhdr[159 - {rx_cnt[4:0], 3'h0} -: 8] <= rx_data_i; // R09
               if (rx_cnt == 16'h0003)
                  tot <= {rhdr[143:136], rx_data_i}; // R13
               if (rx_cnt >= {10'h000, hbytes} && hdr_good) begin
                  rx_pay_valid_o <= 1'b1;
                  rx_pay_data_o <= rx_data_i;
                  if (rx_cnt == {10'h000, hbytes} + 16'h0003) begin
                     rx_app_dst_o <= {hi_byte, rx_data_i}; // R02
                     rx_app_valid_o <= 1'b1;
                  end
                  if (rx_cnt == {10'h000, hbytes} + 16'h0001)
                     rx_app_src_o <= {hi_byte, rx_data_i}; // R02
               end
               if (rx_cnt + 16'h0001 >= tot && (checked || decide))
                  active <= 1'b0; // R13
            end
         end
         // header complete: decide once
         if (decide) begin // R20
            checked <= 1'b1;
            rx_dst_class_o <= next_class;
            rx_dst_kind_o <= next_kind;
            fwd_hop_limit_o <= rhdr[95:88] - 8'h01; // R18
            rx_payload_len_o <= tot - {10'h000, hbytes}; // R13
            if (next_err == 3'h0) begin
               pass <= 1'b1;
               rx_hdr_ok_o <= 1'b1;
               case (rhdr[87:80])
                  `PROTO_ICMP: rx_route_o <= `ROUTE_ICMP; // R01
                  `PROTO_TCP: rx_route_o <= `ROUTE_TCP;
                  `PROTO_UDP: rx_route_o <= `ROUTE_UDP;
                  default: rx_route_o <= `ROUTE_OTHER;
               endcase
            end else begin
               // payload is suppressed; the drop is reported with its error code and source
               active <= 1'b0; // R06
               rx_drop_o <= 1'b1;
               rx_err_code_o <= next_err;
               rx_err_src_o <= rhdr[63:32];
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** src/ipv4_framer_consts.vh ***
// Purpose: constants for the version 4 datagram header framer and checker
// Assumes: one clock, asynchronous active-low reset, byte streams
// Notes: header bytes travel most significant byte first
//
// Notes on behaviour
// R01: transmit header carries 8-bit upper-layer id; receive routes payload by it.
// R02: segments begin with 16-bit source then 16-bit destination application ids.
// R03: link frame header carries a 16-bit type naming the network protocol.
// R04: addresses are 32 bits, class A to E chosen by the leading byte.
// R05: destination kinds: single host, all hosts on network, multicast group.
// R06: a bad datagram is dropped whole and an error report is requested.
// R07: every datagram handled alone; no state kept between datagrams; a decision on a first-byte edge still writes checked, pass or active.
// R08: header is 20 bytes without options; options lengthen it.
// R09: multi-byte integers go out most significant byte first.
// R10: version 4 written on transmit and checked on receive.
// R11: header length counts 32-bit words, so at most 60 bytes.
// R12: at most one service bit set, spare bit zero, precedence ignored.
// R13: total length in bytes locates payload start and size.
// R14: identification filled per datagram and increased by one each time.
// R15: word one: version, header length, service type, total length; word two: id, flags, offset.
// R16: word three: hop limit, upper-layer id, checksum; then source and destination.
// R17: checksum covers the header bytes only, never payload.
// R18: forwarding lowers hop limit by one; zero means discard and report.
// R19: checksum is ones' complement of ones' complement word sum, checksum taken as zero.
// R20: drop datagrams with header length below five or total below header length.
`ifndef IPV4_FRAMER_CONSTS_VH
`define IPV4_FRAMER_CONSTS_VH
`define IP_VERSION 4'h4
`define IP_MIN_IHL 4'h5
`define IP_HDR_BYTES 6'h14
`define ETH_TYPE_IPV4 16'h0800
`define PROTO_ICMP 8'h01
`define PROTO_TCP 8'h06
`define PROTO_UDP 8'h11
`define CLASS_A_TOP 8'h7F
`define CLASS_B_TOP 8'hBF
`define CLASS_C_TOP 8'hDF
`define CLASS_D_TOP 8'hEF
`define CLS_A 3'h0
`define CLS_B 3'h1
`define CLS_C 3'h2
`define CLS_D 3'h3
`define CLS_E 3'h4
`define KIND_UNICAST 2'h0
`define KIND_BROADCAST 2'h1
`define KIND_MULTICAST 2'h2
`define ROUTE_OTHER 2'h0
`define ROUTE_ICMP 2'h1
`define ROUTE_TCP 2'h2
`define ROUTE_UDP 2'h3
`define ERR_VERSION 3'h1
`define ERR_LENGTH 3'h2
`define ERR_CHECKSUM 3'h3
`define ERR_HOPS 3'h4
`define ERR_SERVICE 3'h5
`endif

// *** src/ones_sum16.v ***
// Purpose: running ones' complement sum of 16-bit words
// Assumes: words are offered one per enabled cycle
// Notes: end-around carry folded every step
`timescale 1ns/10ps
`default_nettype none
module ones_sum16 (
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   // control
   input wire clear_i,
   input wire add_i,
   input wire [15:0] word_i,
   // result
   output reg [15:0] sum_o
);
   wire [16:0] raw;
   assign raw = {1'b0, sum_o} + {1'b0, word_i};
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         sum_o <= 16'h0000;
      else if (clear_i)
         sum_o <= 16'h0000;
      else if (add_i)
         sum_o <= raw[15:0] + {15'h0000, raw[16]}; // R19
   end
endmodule
`default_nettype wire

// *** verification/ipv4_header_framer_properties.sv ***
// Purpose: port checks for the datagram header framer
// Assumes: one clock, async active-low reset
// Notes: sees top ports only
`timescale 1ns/10ps
`default_nettype none
`include "ipv4_framer_consts.vh"
module ipv4_header_framer_properties (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // transmit side
   input wire logic tx_start_i,
   input wire logic tx_busy_o,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_last_o,
   input wire logic [15:0] tx_link_type_o,
   // receive side
   input wire logic rx_hdr_ok_o,
   input wire logic rx_drop_o,
   input wire logic [2:0] rx_err_code_o,
   input wire logic rx_pay_valid_o,
   input wire logic [2:0] rx_dst_class_o,
   input wire logic [1:0] rx_dst_kind_o,
   input wire logic [7:0] fwd_hop_limit_o
);
   // --------
   // properties
   // --------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence tx_take;
      tx_start_i && !tx_busy_o;
   endsequence
   sequence tx_head;
      tx_valid_o && tx_data_o == {`IP_VERSION, `IP_MIN_IHL};
   endsequence
   link_type_fixed_a: assert property (tx_link_type_o == `ETH_TYPE_IPV4)
      else $error("frame type wrong");
   first_byte_a: assert property (tx_take |-> ##13 tx_head)
      else $error("first header byte wrong or late");
   last_byte_a: assert property (tx_take |-> ##32 (tx_last_o && tx_valid_o))
      else $error("byte 20 not last");
   busy_held_a: assert property (tx_take |=> tx_busy_o [*8])
      else $error("busy dropped early");
   burst_unbroken_a: assert property (tx_valid_o && !tx_last_o |=> tx_valid_o)
      else $error("gap in header bytes");
   busy_ends_a: assert property (tx_last_o |-> !tx_busy_o)
      else $error("busy after last byte");
   drop_has_code_a: assert property (rx_drop_o |-> !rx_hdr_ok_o && rx_err_code_o != 3'h0)
      else $error("drop without code");
   drop_no_payload_a: assert property (rx_drop_o |=> !rx_pay_valid_o [*2])
      else $error("payload after drop");
   hop_passed_a: assert property (rx_hdr_ok_o |-> fwd_hop_limit_o != 8'hFF)
      else $error("zero hop limit passed");
   multicast_class_a: assert property (rx_dst_kind_o == `KIND_MULTICAST |-> rx_dst_class_o == `CLS_D)
      else $error("multicast outside class D");
endmodule
`default_nettype wire

// *** verification/ipv4_link_partner.sv ***
// Purpose: link-side source of received datagram bytes
// Assumes: bytes change just after rising edges
// Notes: idle data shows inverted last byte, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module ipv4_link_partner (
   input wire logic clk_i,
   output logic valid_o,
   output logic [7:0] data_o,
   output logic first_o
);
   logic [7:0] mem [0:63];
   initial begin
      valid_o = 1'b0;
      first_o = 1'b0;
      data_o = 8'h00;
   end
   task put16(input int idx, input logic [15:0] v);
      mem[idx] = v[15:8];
      mem[idx + 1] = v[7:0];
   endtask
   // segment head: source id then destination id
   task app(input logic [15:0] s, input logic [15:0] d);
      put16(20, s);
      put16(22, d);
      put16(24, 16'h0008);
      put16(26, 16'h0000);
   endtask
   task send(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         valid_o <= 1'b1;
         first_o <= (i == 0);
         data_o <= mem[i];
      end
      @(posedge clk_i);
      valid_o <= 1'b0;
      first_o <= 1'b0;
      data_o <= ~mem[n - 1];
   endtask
endmodule
`default_nettype wire

// *** verification/test_ipv4_header_framer.sv ***
// Purpose: self-checking bench for the header framer
// Assumes: 20 MHz clock, fixed header fields
// Notes: expected headers built here, checksum included
`timescale 1ns/10ps
`default_nettype none
`include "ipv4_framer_consts.vh"
module test_ipv4_header_framer;
   localparam logic [31:0] SRC = 32'hC0A80105;
   localparam logic [31:0] DST = 32'h0A000002;
   localparam logic [7:0] LEADS [0:4] = '{8'h7F, 8'h80, 8'hDF, 8'hE0, 8'hF0};
   localparam logic [7:0] PROTOS [0:3] = '{8'h01, 8'h06, 8'h11, 8'h63};
   logic clk_i, rstn_i, tx_start_i;
   logic [15:0] tx_total_len_i;
   logic [7:0] tx_proto_i, tx_hop_limit_i;
   logic [3:0] tx_service_type_bits_i;
   logic [2:0] tx_flags_i;
   logic [12:0] tx_frag_off_i;
   logic [31:0] tx_src_addr_i, tx_dst_addr_i, local_addr_i, local_mask_i;
   wire logic rx_valid_i, rx_first_i, tx_busy_o, tx_valid_o, tx_last_o, rx_hdr_ok_o, rx_drop_o;
   wire logic rx_app_valid_o, rx_pay_valid_o;
   wire logic [7:0] rx_data_i, tx_data_o, rx_pay_data_o, fwd_hop_limit_o;
   wire logic [15:0] tx_link_type_o, rx_payload_len_o, rx_app_src_o, rx_app_dst_o;
   wire logic [2:0] rx_err_code_o, rx_dst_class_o;
   wire logic [31:0] rx_err_src_o;
   wire logic [1:0] rx_route_o, rx_dst_kind_o;
   logic [7:0] h [0:19];
   logic got_ok, got_drop;
   logic [15:0] app_s, app_d;
   int pay_n, miscompares, check_count;
   ipv4_header_framer uut (
      .clk_i(clk_i), .rstn_i(rstn_i), .tx_start_i(tx_start_i), .tx_total_len_i(tx_total_len_i),
      .tx_proto_i(tx_proto_i), .tx_hop_limit_i(tx_hop_limit_i), .tx_service_type_bits_i(tx_service_type_bits_i),
      .tx_flags_i(tx_flags_i), .tx_frag_off_i(tx_frag_off_i), .tx_src_addr_i(tx_src_addr_i),
      .tx_dst_addr_i(tx_dst_addr_i), .tx_busy_o(tx_busy_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
      .tx_last_o(tx_last_o), .tx_link_type_o(tx_link_type_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
      .rx_first_i(rx_first_i), .local_addr_i(local_addr_i), .local_mask_i(local_mask_i),
      .rx_hdr_ok_o(rx_hdr_ok_o), .rx_drop_o(rx_drop_o), .rx_err_code_o(rx_err_code_o),
      .rx_err_src_o(rx_err_src_o), .rx_route_o(rx_route_o), .rx_dst_class_o(rx_dst_class_o),
      .rx_dst_kind_o(rx_dst_kind_o), .rx_payload_len_o(rx_payload_len_o), .rx_app_src_o(rx_app_src_o),
      .rx_app_dst_o(rx_app_dst_o), .rx_app_valid_o(rx_app_valid_o), .rx_pay_valid_o(rx_pay_valid_o),
      .rx_pay_data_o(rx_pay_data_o), .fwd_hop_limit_o(fwd_hop_limit_o)
   );
   ipv4_link_partner link (.clk_i(clk_i), .valid_o(rx_valid_i), .data_o(rx_data_i), .first_o(rx_first_i));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (rx_hdr_ok_o === 1'b1) got_ok <= 1'b1;
      if (rx_drop_o === 1'b1) got_drop <= 1'b1;
      if (rx_pay_valid_o === 1'b1) begin
         chk(rx_pay_data_o, link.mem[20 + pay_n]);
         pay_n <= pay_n + 1;
      end
      if (rx_app_valid_o === 1'b1) begin
         app_s <= rx_app_src_o;
         app_d <= rx_app_dst_o;
      end
   end
   // --------
   // shared tasks
   // --------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task mk_hdr(input logic [7:0] vi, service_type_bits, input logic [15:0] id, input logic [7:0] hop, pr,
               input logic [31:0] dst);
      logic [31:0] s;
      {h[0], h[1], h[2], h[3]} = {vi, service_type_bits, 16'h001C};
      {h[4], h[5], h[6], h[7]} = {id, 3'h2, 13'h0005};
      {h[8], h[9], h[10], h[11]} = {hop, pr, 16'h0000};
      {h[12], h[13], h[14], h[15]} = SRC;
      {h[16], h[17], h[18], h[19]} = dst;
      s = 32'h0;
      for (int i = 0; i < 20; i += 2) s = s + {h[i], h[i + 1]};
      s = s[15:0] + s[31:16];
      s = s[15:0] + s[31:16];
      {h[10], h[11]} = ~s[15:0];
   endtask
   task rx_run(input logic [7:0] vi, service_type_bits, hop, pr, input logic [31:0] dst, input logic bad,
               input logic [2:0] code);
      mk_hdr(vi, service_type_bits, 16'h0000, hop, pr, dst);
      if (bad) h[11] = ~h[11];
      for (int i = 0; i < 20; i++) link.mem[i] = h[i];
      link.app(16'h1234, 16'h0050);
      got_ok = 1'b0;
      got_drop = 1'b0;
      pay_n = 0;
      link.send(28);
      repeat (3) @(posedge clk_i);
      #1;
      chk(got_drop, code != 3'h0);
      chk(got_ok, code == 3'h0);
      if (code != 3'h0) begin
         chk(rx_err_code_o, code);
         chk(rx_err_src_o, SRC);
      end else begin
         chk(rx_payload_len_o, 16'h0008);
         chk(pay_n, 8);
         chk({app_s, app_d}, 32'h12340050);
         chk(fwd_hop_limit_o, hop - 8'h01);
      end
   endtask
   // --------
   // scenarios
   // --------
   task t_tx(input logic [3:0] service_type_bits, input logic [15:0] id);
      int n;
      mk_hdr(8'h45, $onehot0(service_type_bits) ? {3'h0, service_type_bits, 1'b0} : 8'h00, id, 8'h40, `PROTO_UDP, DST);
      @(posedge clk_i);
      tx_service_type_bits_i <= service_type_bits;
      tx_start_i <= 1'b1;
      @(posedge clk_i);
      tx_start_i <= 1'b0;
      n = 0;
      for (int c = 0; c < 50 && n < 20; c++) begin
         @(posedge clk_i);
         #1;
         if (tx_valid_o === 1'b1) begin
            chk(tx_data_o, h[n]);
            if (n == 0) chk(tx_busy_o, 1'b1);
            if (n == 19) chk(tx_last_o, 1'b1);
            n++;
         end
      end
      chk(n, 20);
      chk(tx_busy_o, 1'b0);
      chk(tx_link_type_o, `ETH_TYPE_IPV4);
      $display("tx test done, id %h", id);
   endtask
   task t_err;
      rx_run(8'h45, 8'h10, 8'h40, `PROTO_UDP, DST, 1'b0, 3'h0);
      rx_run(8'h55, 8'h00, 8'h40, `PROTO_UDP, DST, 1'b0, `ERR_VERSION);
      rx_run(8'h44, 8'h00, 8'h40, `PROTO_UDP, DST, 1'b0, `ERR_LENGTH);
      rx_run(8'h45, 8'h00, 8'h40, `PROTO_UDP, DST, 1'b1, `ERR_CHECKSUM);
      rx_run(8'h45, 8'h00, 8'h00, `PROTO_UDP, DST, 1'b0, `ERR_HOPS);
      rx_run(8'h45, 8'h0C, 8'h40, `PROTO_UDP, DST, 1'b0, `ERR_SERVICE);
      rx_run(8'h45, 8'h00, 8'h01, `PROTO_UDP, DST, 1'b0, 3'h0);
      $display("receive error test done");
   endtask
   task t_class;
      for (int i = 0; i < 5; i++) begin
         rx_run(8'h45, 8'h00, 8'h40, `PROTO_UDP, {LEADS[i], 24'h010203}, 1'b0, 3'h0);
         chk(rx_dst_class_o, i);
         chk(rx_dst_kind_o, i == 3 ? `KIND_MULTICAST : `KIND_UNICAST);
      end
      rx_run(8'h45, 8'h00, 8'h40, `PROTO_UDP, 32'hFFFFFFFF, 1'b0, 3'h0);
      chk(rx_dst_kind_o, `KIND_BROADCAST);
      rx_run(8'h45, 8'h00, 8'h40, `PROTO_UDP, 32'h0A0000FF, 1'b0, 3'h0);
      chk(rx_dst_kind_o, `KIND_BROADCAST);
      $display("address class test done");
   endtask
   task t_route;
      for (int i = 0; i < 4; i++) begin
         rx_run(8'h45, 8'h00, 8'h40, PROTOS[i], DST, 1'b0, 3'h0);
         chk(rx_route_o, (i + 1) % 4);
      end
      $display("route test done");
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      rstn_i = 1'b0;
      tx_start_i = 1'b0;
      tx_total_len_i = 16'h001C;
      tx_proto_i = `PROTO_UDP;
      tx_hop_limit_i = 8'h40;
      tx_service_type_bits_i = 4'h0;
      tx_flags_i = 3'h2;
      tx_frag_off_i = 13'h0005;
      tx_src_addr_i = SRC;
      tx_dst_addr_i = DST;
      local_addr_i = DST;
      local_mask_i = 32'hFFFFFF00;
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_tx(4'h2, 16'h0000);
      t_tx(4'h3, 16'h0001);
      t_err;
      t_class;
      t_route;
      final_report;
   end
   // cut a hang short: about three times the expected run
   initial begin
      #100000;
      miscompares++;
      final_report;
   end
endmodule
bind ipv4_header_framer ipv4_header_framer_properties chk_props (
   .clk_i(clk_i), .rstn_i(rstn_i), .tx_start_i(tx_start_i), .tx_busy_o(tx_busy_o),
   .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_link_type_o(tx_link_type_o),
   .rx_hdr_ok_o(rx_hdr_ok_o), .rx_drop_o(rx_drop_o), .rx_err_code_o(rx_err_code_o),
   .rx_pay_valid_o(rx_pay_valid_o), .rx_dst_class_o(rx_dst_class_o), .rx_dst_kind_o(rx_dst_kind_o),
   .fwd_hop_limit_o(fwd_hop_limit_o)
);
`default_nettype wire
